/* dv/i2c_master_sequencer_asserts.sv */
// Concurrent checks on the two-wire master sequencer ports.
// Assumes requests arrive as one-cycle strobes on mclk.
`timescale 1ns/1ps

module seq_asserts (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       buf_write,
  input wire logic [7:0] buf_write_data,
  input wire logic       buf_read,
  input wire logic       start_set,
  input wire logic       restart_set,
  input wire logic       receive_set,
  input wire logic       sda_in,
  input wire logic [7:0] transfer_buffer,
  input wire logic       buffer_full_flag,
  input wire logic       write_collision_flag,
  input wire logic       collision_event_flag,
  input wire logic       port_event_flag,
  input wire logic       start_seen,
  input wire logic       start_request,
  input wire logic       restart_request,
  input wire logic       receive_request,
  input wire logic       ack_send_request,
  input wire logic       port_idle,
  input wire logic       scl_oe,
  input wire logic       sda_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  write_collision_flag_busy_a: assert property (
    buf_write && !port_idle |=> write_collision_flag && transfer_buffer == $past(transfer_buffer))
    else $error("busy buffer write not refused");
  tx_load_a: assert property (
    buf_write && port_idle |=> buffer_full_flag && !port_idle
      && transfer_buffer == $past(buf_write_data))
    else $error("idle buffer write did not load");
  rx_ignore_a: assert property (
    receive_set && !port_idle && !receive_request |=> !receive_request)
    else $error("receive taken while busy");
  rs_ignore_a: assert property (
    restart_set && !port_idle && !restart_request |=> !restart_request)
    else $error("restart taken while busy");
  idle_def_a: assert property (
    port_idle |-> !(start_request || restart_request || receive_request || ack_send_request))
    else $error("idle with a sequence active");
  start_abort_a: assert property (
    start_set && port_idle && !sda_in && !$past(sda_in) && !$past(sda_in, 2)
      |-> ##[1:6] (collision_event_flag && port_idle && !start_request))
    else $error("start on low data not aborted");
  start_cond_a: assert property (
    $rose(start_seen) |-> sda_oe && !scl_oe)
    else $error("start seen without data low");
  start_done_a: assert property (
    $fell(start_request) && sda_oe |-> scl_oe && port_event_flag)
    else $error("start end wrong");
  sda_stable_a: assert property (
    buffer_full_flag && $past(buffer_full_flag) && !scl_oe && !$past(scl_oe)
      |-> $stable(sda_oe))
    else $error("data moved while clock high");
  tx_release_a: assert property (
    $fell(buffer_full_flag) && !$past(buf_read) |-> !sda_oe)
    else $error("data not released after byte");
  read_clear_a: assert property (
    buf_read && port_idle && !buf_write |=> !buffer_full_flag)
    else $error("read did not clear full");
endmodule : seq_asserts

bind i2c_master_sequencer seq_asserts chk (.mclk, .reset_n, .buf_write, .buf_write_data,
  .buf_read, .start_set, .restart_set, .receive_set, .sda_in, .transfer_buffer,
  .buffer_full_flag, .write_collision_flag, .collision_event_flag, .port_event_flag,
  .start_seen, .start_request, .restart_request, .receive_request, .ack_send_request,
  .port_idle, .scl_oe, .sda_oe);

/* dv/i2c_slave_model.sv */
// Behavioural slave at the far end of the two-wire bus.
// Assumes wired-AND lines with pull-ups; arm restarts its fall count.
`timescale 1ns/1ps

module i2c_slave_model (
  input  wire logic       arm,       // Restart fall count
  input  wire logic       send,      // Drive a byte instead of acknowledging
  input  wire logic [7:0] data,      // Byte to drive, MSB first
  input  wire logic       ack,       // Acknowledge a written byte
  input  wire logic       stretch,   // Hold clock low after each fall
  input  wire logic       scl,       // Clock line level
  output logic            sda_pull,  // Pull data low
  output logic            scl_pull   // Pull clock low
);
  int cnt;  // Clock falls since arm

  // Count clock falls
  always @(posedge arm or negedge scl) begin
    if (arm) cnt <= 0;
    else cnt <= cnt + 1;
  end

  // Byte bits, then the acknowledge window; released lines float high
  always_comb begin
    if (send) sda_pull = (cnt < 8) && !data[7 - cnt];
    else sda_pull = ack && (cnt == 8);
  end

  // Slow slave keeps the clock low for a while
  initial scl_pull = 1'b0;
  always @(negedge scl) begin
    if (stretch) begin
      scl_pull = 1'b1;
      #3000 scl_pull = 1'b0;
    end
  end
endmodule : i2c_slave_model

/* dv/tb_i2c_master_sequencer.sv */
// Self-checking bench for the two-wire master sequencer.
// Assumes the slave model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_i2c_master_sequencer;
  import i2c_seq_pkg::*;
  logic        mclk, reset_n, akd, arm, snd, ak, st, hold;
  logic [11:0] s;            // Request and clear strobes
  logic [7:0]  wd, dat, starts, exp_starts;
  logic [8:0]  cap;          // Last nine bits seen at clock rises
  logic [7:0]  transfer_buffer;
  logic        buffer_full_flag, write_collision_flag, receive_overflow_flag;
  logic        ack_received_status, port_event_flag, collision_event_flag, start_seen;
  logic        start_request, restart_request, stop_request, receive_request;
  logic        ack_send_request, ack_send_value, port_idle, scl_oe, sda_oe;
  logic        sda_pull, scl_pull, scl_out, sda_out;
  wire         scl_w = !((scl_oe && !scl_out) || scl_pull);
  wire         sda_w = !((sda_oe && !sda_out) || sda_pull || hold);
  int          miscompares, total_checks, cycles;

  i2c_master_sequencer dut (.mclk, .reset_n, .baud_reload_value(8'h03),
    .buf_write(s[0]), .buf_write_data(wd), .buf_read(s[1]), .start_set(s[2]),
    .restart_set(s[3]), .stop_set(s[4]), .receive_set(s[5]), .ack_set(s[6]),
    .ack_value_write(s[7]), .ack_value_data(akd), .write_collision_flag_clear(s[8]), .event_clear(s[9]),
    .collision_clear(s[10]), .overflow_clear(s[11]), .transfer_buffer, .buffer_full_flag,
    .write_collision_flag, .receive_overflow_flag, .ack_received_status, .port_event_flag,
    .collision_event_flag, .start_seen, .start_request, .restart_request, .stop_request,
    .receive_request, .ack_send_request, .ack_send_value, .port_idle, .scl_in(scl_w),
    .sda_in(sda_w), .scl_oe, .sda_oe, .scl_out, .sda_out);

  i2c_slave_model slave (.arm, .send(snd), .data(dat), .ack(ak), .stretch(st), .scl(scl_w),
    .sda_pull, .scl_pull);

  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Bits seen at clock rises, start conditions seen on the wire
  always @(posedge scl_w) cap <= {cap[7:0], sda_w};
  always @(negedge sda_w) if (scl_w === 1'b1) starts <= starts + 8'h01;

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task pulse(input logic [11:0] m);
    @(negedge mclk) s = m;
    @(negedge mclk) s = 12'h000;
  endtask : pulse

  task wait_done();
    wait (port_event_flag === 1'b1 || collision_event_flag === 1'b1);
    @(negedge mclk);
  endtask : wait_done

  // Clear flags, set up the slave, issue one request, wait for its end
  task op(input logic [11:0] m, input logic sn, input logic [7:0] d);
    pulse(12'hf00);
    snd = sn;
    dat = d;
    wd = d;
    arm = 1'b1;
    pulse(m);
    arm = 1'b0;
    wait_done();
  endtask : op

  task summarize();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    {reset_n, akd, arm, snd, ak, st, hold} = 7'h00;
    {s, wd, dat, starts} = '0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("port_idle", 8'h01, port_idle);
    hold = 1'b1;
    op(12'h004, 1'b0, 8'h00);
    chk("collision", 8'h01, collision_event_flag);
    chk("start_seen", 8'h00, start_seen);
    hold = 1'b0;
    pulse(12'hf00);
    pulse(12'h004);
    {wd, akd} = {8'h77, 1'b1};
    pulse(12'h0b9);
    wait_done();
    chk("write_collision_flag", 8'h01, write_collision_flag);
    chk("buffer", 8'h00, transfer_buffer);
    chk("ack_value", 8'h00, ack_send_value);
    chk("stop_req", 8'h00, stop_request);
    chk("start_seen", 8'h01, start_seen);
    chk("start_req", 8'h00, start_request);
    chk("sda_oe", 8'h01, sda_oe);
    chk("restart_req", 8'h00, restart_request);
    chk("receive_req", 8'h00, receive_request);
    ak = 1'b1;
    op(12'h001, 1'b0, 8'ha5);
    chk("addr_bits", 8'ha5, cap[8:1]);
    chk("ack_status", 8'h00, ack_received_status);
    chk("full", 8'h00, buffer_full_flag);
    chk("scl_oe", 8'h01, scl_oe);
    chk("event", 8'h01, port_event_flag);
    chk("write_collision_flag", 8'h00, write_collision_flag);
    {ak, st} = 2'b01;
    op(12'h001, 1'b0, 8'h3c);
    chk("data_bits", 8'h3c, cap[8:1]);
    chk("ack_status", 8'h01, ack_received_status);
    st = 1'b0;
    op(12'h020, 1'b1, 8'h96);
    chk("rx_byte", 8'h96, transfer_buffer);
    chk("full", 8'h01, buffer_full_flag);
    chk("receive_req", 8'h00, receive_request);
    op(12'h020, 1'b1, 8'h5a);
    chk("overflow", 8'h01, receive_overflow_flag);
    pulse(12'h002);
    chk("full", 8'h00, buffer_full_flag);
    pulse(12'h080);
    op(12'h040, 1'b0, 8'h00);
    chk("ack_sent", 8'h01, {7'h00, cap[0]});
    chk("ack_req", 8'h00, ack_send_request);
    exp_starts = starts + 8'h01;
    op(12'h008, 1'b0, 8'h00);
    chk("starts", exp_starts, starts);
    chk("restart_req", 8'h00, restart_request);
    chk("sda_oe", 8'h01, sda_oe);
    chk("event", 8'h01, port_event_flag);
    chk("collision", 8'h00, collision_event_flag);
    hold = 1'b1;
    op(12'h008, 1'b0, 8'h00);
    chk("collision", 8'h01, collision_event_flag);
    chk("port_idle", 8'h01, port_idle);
    pulse(12'h010);
    chk("stop_req", 8'h01, stop_request);
    summarize();
  end
endmodule : tb_i2c_master_sequencer

/* hw/i2c_master_sequencer.sv */
// Master sequencer of a two-wire serial port: start, restart, byte transmit,
// byte receive and acknowledge send, timed by a reloadable baud counter.
// Assumes open-drain pads outside; line inputs are asynchronous to mclk.
`timescale 1ns/1ps

module i2c_master_sequencer
  import i2c_seq_pkg::*;
#(
  parameter logic [7:0] RELOAD_DEFAULT = i2c_seq_pkg::RELOAD_RESET  // Reset reload value
) (
  input  wire logic       mclk,                  // System clock
  input  wire logic       reset_n,               // Synchronous reset, active low
  // Processor side
  input  wire logic [7:0] baud_reload_value,     // Baud counter reload value
  input  wire logic       buf_write,             // Transfer buffer write strobe
  input  wire logic [7:0] buf_write_data,        // Transfer buffer write data
  input  wire logic       buf_read,              // Transfer buffer read strobe
  input  wire logic       start_set,             // Set start_request
  input  wire logic       restart_set,           // Set restart_request
  input  wire logic       stop_set,              // Set stop_request (held only)
  input  wire logic       receive_set,           // Set receive_request
  input  wire logic       ack_set,               // Set ack_send_request
  input  wire logic       ack_value_write,       // Write ack_send_value
  input  wire logic       ack_value_data,        // New ack_send_value
  input  wire logic       write_collision_flag_clear,            // Clear write_collision_flag
  input  wire logic       event_clear,           // Clear port_event_flag
  input  wire logic       collision_clear,       // Clear collision_event_flag
  input  wire logic       overflow_clear,        // Clear receive_overflow_flag
  output logic      [7:0] transfer_buffer,       // Transfer buffer contents
  output logic            buffer_full_flag,      // Buffer holds unread/unsent byte
  output logic            write_collision_flag,  // Discarded buffer write
  output logic            receive_overflow_flag, // Byte arrived while full
  output logic            ack_received_status,   // Slave did not acknowledge
  output logic            port_event_flag,       // Sequence complete event
  output logic            collision_event_flag,  // Bus collision event
  output logic            start_seen,            // Start condition generated
  output logic            start_request,         // Start in progress
  output logic            restart_request,       // Restart in progress
  output logic            stop_request,          // Stop requested (not sequenced)
  output logic            receive_request,       // Receive in progress
  output logic            ack_send_request,      // Acknowledge in progress
  output logic            ack_send_value,        // Acknowledge level to send
  output logic            port_idle,             // No sequence active
  // Bus side
  input  wire logic       scl_in,                // Clock line level
  input  wire logic       sda_in,                // Data line level
  output logic            scl_oe,                // Pull clock low while high
  output logic            sda_oe,                // Pull data low while high
  output logic            scl_out,               // Clock drive level, always low
  output logic            sda_out                // Data drive level, always low
);
  import i2c_seq_pkg::*;

  // Complete module state
  typedef struct packed {
    logic [SYNC_STAGES-1:0] scl_sync;    // Clock synchroniser
    logic [SYNC_STAGES-1:0] sda_sync;    // Data synchroniser
    seq_state_e state;                   // Sequencer state
    logic [7:0] baud_counter;            // Baud period counter
    logic [7:0] shift_register;          // Shift register
    logic [3:0] bit_count;               // Bits done in this byte
    logic [7:0] transfer_buffer;         // Transfer buffer
    logic       buffer_full_flag;        // Buffer full
    logic       write_collision_flag;    // Write collision
    logic       receive_overflow_flag;   // Receive overflow
    logic       ack_received_status;     // Acknowledge status
    logic       port_event_flag;         // Event flag
    logic       collision_event_flag;    // Collision flag
    logic       start_seen;              // Start condition seen
    logic       start_request;           // Start request bit
    logic       restart_request;         // Restart request bit
    logic       stop_request;            // Stop request bit
    logic       receive_request;         // Receive request bit
    logic       ack_send_request;        // Acknowledge request bit
    logic       ack_send_value;          // Acknowledge value bit
    logic       port_idle;               // Idle indication
    logic       scl_oe;                  // Clock pull-down
    logic       sda_oe;                  // Data pull-down
  } seq_s;

  seq_s cur;       // Registered state
  seq_s next_cur;  // Next state

  // Counter reached terminal count
  function automatic logic baud_done(input logic [7:0] cnt);
    baud_done = (cnt == BYTE_ZERO);
  endfunction : baud_done

  // Sampled line levels from the second synchroniser stage
  logic scl_s;
  logic sda_s;
  assign scl_s = cur.scl_sync[SYNC_STAGES-1];
  assign sda_s = cur.sda_sync[SYNC_STAGES-1];

  // Next-state logic
  always_comb begin
    logic tick;      // Baud period expired
    logic busy;      // Any sequence active
    logic reload;    // Reload baud counter
    next_cur = cur;
    tick   = baud_done(cur.baud_counter);
    busy   = (cur.state != ST_IDLE);
    reload = 1'b0;

    // Synchronisers: first stage read only by second
    next_cur.scl_sync = {cur.scl_sync[SYNC_STAGES-2:0], scl_in};
    next_cur.sda_sync = {cur.sda_sync[SYNC_STAGES-2:0], sda_in};

    // Countdown that stops at zero, reloaded below where a phase begins
    if (!tick) begin
      next_cur.baud_counter = cur.baud_counter - 8'h01;
    end

    // Software clears; set below wins because it is assigned later
    if (write_collision_flag_clear) begin
      next_cur.write_collision_flag = 1'b0;
    end
    if (event_clear) begin
      next_cur.port_event_flag = 1'b0;
    end
    if (collision_clear) begin
      next_cur.collision_event_flag = 1'b0;
    end
    if (overflow_clear) begin
      next_cur.receive_overflow_flag = 1'b0;
    end
    if (buf_read) begin
      next_cur.buffer_full_flag = 1'b0;
    end

    // Control register writes; blocked while a start runs
    if (!cur.start_request) begin
      if (ack_value_write) begin
        next_cur.ack_send_value = ack_value_data;
      end
      if (stop_set) begin
        next_cur.stop_request = 1'b1;
      end
    end

    // Buffer write: discarded when busy, starts transmit when idle
    if (buf_write) begin
      if (busy) begin
        next_cur.write_collision_flag = 1'b1;
      end else begin
        next_cur.transfer_buffer  = buf_write_data;
        next_cur.shift_register   = buf_write_data;
        next_cur.buffer_full_flag = 1'b1;
        next_cur.bit_count        = 4'h0;
        next_cur.state            = ST_TX_LOW;
        next_cur.scl_oe           = 1'b1;
        next_cur.sda_oe           = ~buf_write_data[7];
        reload                    = 1'b1;
      end
    end else if (!busy && !cur.start_request) begin
      // New requests only take effect from idle
      if (start_set) begin
        if (!scl_s || !sda_s) begin
          next_cur.collision_event_flag = 1'b1;
        end else begin
          next_cur.start_request = 1'b1;
          next_cur.state         = ST_START_WAIT;
          reload                 = 1'b1;
        end
      end else if (restart_set) begin
        next_cur.restart_request = 1'b1;
        next_cur.scl_oe          = 1'b1;
        next_cur.state           = ST_RS_SCL_LOW;
      end else if (receive_set) begin
        next_cur.receive_request = 1'b1;
        next_cur.bit_count       = 4'h0;
        next_cur.scl_oe          = 1'b1;
        next_cur.sda_oe          = 1'b0;
        next_cur.state           = ST_RX_LOW;
        reload                   = 1'b1;
      end else if (ack_set) begin
        next_cur.ack_send_request = 1'b1;
        next_cur.scl_oe           = 1'b1;
        next_cur.sda_oe           = ~cur.ack_send_value;
        next_cur.state            = ST_ACK_LOW;
        reload                    = 1'b1;
      end
    end

    // Sequencer
    case (cur.state)
      ST_IDLE: begin
      end
      ST_START_WAIT: begin
        if (!scl_s || !sda_s) begin
          next_cur.collision_event_flag = 1'b1;
          next_cur.start_request        = 1'b0;
          next_cur.state                = ST_IDLE;
        end else if (tick) begin
          next_cur.sda_oe     = 1'b1;
          next_cur.start_seen = 1'b1;
          next_cur.state      = ST_START_HOLD;
          reload              = 1'b1;
        end
      end
      ST_START_HOLD: begin
        if (tick) begin
          next_cur.start_request   = 1'b0;
          next_cur.port_event_flag = 1'b1;
          next_cur.scl_oe          = 1'b1;
          next_cur.state           = ST_IDLE;
        end
      end
      ST_RS_SCL_LOW: begin
        if (!scl_s) begin
          next_cur.sda_oe = 1'b0;
          next_cur.state  = ST_RS_SDA_HIGH;
          reload          = 1'b1;
        end
      end
      ST_RS_SDA_HIGH: begin
        if (tick) begin
          if (sda_s) begin
            next_cur.scl_oe = 1'b0;
            next_cur.state  = ST_RS_SCL_REL;
          end else begin
            next_cur.collision_event_flag = 1'b1;
            next_cur.restart_request      = 1'b0;
            next_cur.scl_oe               = 1'b0;
            next_cur.state                = ST_IDLE;
          end
        end
      end
      ST_RS_SCL_REL: begin
        if (scl_s) begin
          if (!sda_s) begin
            next_cur.collision_event_flag = 1'b1;
            next_cur.restart_request      = 1'b0;
            next_cur.state                = ST_IDLE;
          end else begin
            next_cur.state = ST_RS_BOTH_HIGH;
            reload         = 1'b1;
          end
        end
      end
      ST_RS_BOTH_HIGH: begin
        if (!scl_s) begin
          next_cur.collision_event_flag = 1'b1;
          next_cur.restart_request      = 1'b0;
          next_cur.state                = ST_IDLE;
        end else if (tick) begin
          next_cur.sda_oe     = 1'b1;
          next_cur.start_seen = 1'b1;
          next_cur.state      = ST_RS_SDA_LOW;
          reload              = 1'b1;
        end
      end
      ST_RS_SDA_LOW: begin
        if (tick) begin
          next_cur.scl_oe          = 1'b1;
          next_cur.restart_request = 1'b0;
          next_cur.port_event_flag = 1'b1;
          next_cur.state           = ST_IDLE;
        end
      end
      ST_TX_LOW: begin
        if (tick) begin
          next_cur.scl_oe = 1'b0;
          next_cur.state  = ST_TX_REL;
        end
      end
      ST_TX_REL: begin
        if (scl_s) begin
          next_cur.state = ST_TX_HIGH;
          reload         = 1'b1;
        end
      end
      ST_TX_HIGH: begin
        if (cur.bit_count == BITS_BYTE && scl_s) begin
          next_cur.ack_received_status = sda_s;
        end
        if (tick) begin
          next_cur.scl_oe    = 1'b1;  // Falling edge
          next_cur.bit_count = cur.bit_count + 4'h1;
          if (cur.bit_count + 4'h1 == BITS_BYTE) begin
            next_cur.buffer_full_flag = 1'b0;
            next_cur.sda_oe           = 1'b0;
            next_cur.state            = ST_TX_LOW;
            reload                    = 1'b1;
          end else if (cur.bit_count + 4'h1 == BITS_FRAME) begin
            next_cur.port_event_flag = 1'b1;
            next_cur.state           = ST_IDLE;
          end else begin
            next_cur.shift_register = {cur.shift_register[6:0], 1'b0};
            next_cur.sda_oe         = ~cur.shift_register[6];
            next_cur.state          = ST_TX_LOW;
            reload                  = 1'b1;
          end
        end
      end
      ST_RX_LOW: begin
        if (tick) begin
          next_cur.scl_oe = 1'b0;
          next_cur.state  = ST_RX_REL;
        end
      end
      ST_RX_REL: begin
        if (scl_s) begin
          next_cur.shift_register = {cur.shift_register[6:0], sda_s};
          next_cur.state          = ST_RX_HIGH;
          reload                  = 1'b1;
        end
      end
      ST_RX_HIGH: begin
        if (tick) begin
          next_cur.scl_oe    = 1'b1;
          next_cur.bit_count = cur.bit_count + 4'h1;
          if (cur.bit_count + 4'h1 == BITS_BYTE) begin
            next_cur.receive_request = 1'b0;
            next_cur.transfer_buffer = cur.shift_register;
            next_cur.buffer_full_flag = 1'b1;
            next_cur.port_event_flag = 1'b1;
            next_cur.state           = ST_IDLE;
            if (cur.buffer_full_flag && !buf_read) begin
              next_cur.receive_overflow_flag = 1'b1;
            end
          end else begin
            next_cur.state = ST_RX_LOW;
            reload         = 1'b1;
          end
        end
      end
      ST_ACK_LOW: begin
        if (tick) begin
          next_cur.scl_oe = 1'b0;
          next_cur.state  = ST_ACK_REL;
        end
      end
      ST_ACK_REL: begin
        if (scl_s) begin
          next_cur.state = ST_ACK_HIGH;
          reload         = 1'b1;
        end
      end
      ST_ACK_HIGH: begin
        if (tick) begin
          next_cur.scl_oe           = 1'b1;
          next_cur.ack_send_request = 1'b0;
          next_cur.port_event_flag  = 1'b1;
          next_cur.state            = ST_IDLE;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase

    // Counter reload; otherwise it halts at zero when idle
    if (reload) begin
      next_cur.baud_counter = baud_reload_value;
    end

    // Idle indication from next state and request bits
    next_cur.port_idle = (next_cur.state == ST_IDLE) && !next_cur.start_request
                         && !next_cur.restart_request && !next_cur.receive_request
                         && !next_cur.ack_send_request;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cur              <= '0;
      cur.scl_sync     <= '1;
      cur.sda_sync     <= '1;
      cur.state        <= ST_IDLE;
      cur.baud_counter <= RELOAD_DEFAULT;
      cur.port_idle    <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register; scl_out and sda_out tied low
  assign transfer_buffer       = cur.transfer_buffer;
  assign buffer_full_flag      = cur.buffer_full_flag;
  assign write_collision_flag  = cur.write_collision_flag;
  assign receive_overflow_flag = cur.receive_overflow_flag;
  assign ack_received_status   = cur.ack_received_status;
  assign port_event_flag       = cur.port_event_flag;
  assign collision_event_flag  = cur.collision_event_flag;
  assign start_seen            = cur.start_seen;
  assign start_request         = cur.start_request;
  assign restart_request       = cur.restart_request;
  assign stop_request          = cur.stop_request;
  assign receive_request       = cur.receive_request;
  assign ack_send_request      = cur.ack_send_request;
  assign ack_send_value        = cur.ack_send_value;
  assign port_idle             = cur.port_idle;
  assign scl_oe                = cur.scl_oe;
  assign sda_oe                = cur.sda_oe;
  assign scl_out               = 1'b0;
  assign sda_out               = 1'b0;
endmodule : i2c_master_sequencer

/* hw/i2c_seq_pkg.sv */
// Constants and types for the two-wire master sequencer.
// Assumes a single system clock; no register bus, all control bits are ports.
package i2c_seq_pkg;
  localparam int          CLK_HZ       = 10_000_000;  // System clock rate
  localparam int          SYNC_STAGES  = 2;           // Pin synchroniser depth
  localparam logic [7:0]  RELOAD_RESET = 8'h09;       // Default baud reload value
  localparam logic [3:0]  BITS_BYTE    = 4'h8;        // Data bits per byte
  localparam logic [3:0]  BITS_FRAME   = 4'h9;        // Bits including acknowledge
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;       // Cleared byte value

  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE,
    ST_START_WAIT,     // Start: both lines high, first period
    ST_START_HOLD,     // Start: data low, second period
    ST_RS_SCL_LOW,     // Restart: wait for clock seen low
    ST_RS_SDA_HIGH,    // Restart: data released for a period
    ST_RS_SCL_REL,     // Restart: clock released, wait high
    ST_RS_BOTH_HIGH,   // Restart: both high for a period
    ST_RS_SDA_LOW,     // Restart: data low while clock high
    ST_TX_LOW,         // Transmit: clock low phase
    ST_TX_REL,         // Transmit: clock released, wait high
    ST_TX_HIGH,        // Transmit: clock high phase
    ST_RX_LOW,         // Receive: clock low phase
    ST_RX_REL,         // Receive: clock released, wait high
    ST_RX_HIGH,        // Receive: clock high phase
    ST_ACK_LOW,        // Acknowledge: clock low, value driven
    ST_ACK_REL,        // Acknowledge: clock released, wait high
    ST_ACK_HIGH        // Acknowledge: clock high phase
  } seq_state_e;
endpackage : i2c_seq_pkg
